/* File: wlc_pkg.sv */
// Constants, types and the summary of operation for the limit-check block
// Summary of operation
// - Classify the current result as exactly one of LO, OK or HI.
// - Compare piece count in counting mode, weight in weighing and auto-tare modes.
// - No checking while weight stays below twenty display divisions.
// - High limit zero: only test result at or below low limit.
// - Low limit zero: only test result at or above high limit.
// - Equal limits act as an equality check against that value.
// - Six-digit low then high limit, each confirmed, then checking is enabled.
// - Clear key during entry zeroes that limit and cancels checking.
// - In styles 2 to 4, LO shows yellow, OK shows green, HI shows red.
// - Five bar styles coded 0 to 4; style 0 keeps the bar dark.
// - Style 1 lights the bar from the zero end to the result position.
// - Style 2 lights all eight LEDs of the result colour.
// - Style 3 lights one LED of the result colour at a value-derived place.
// - Style 4 lights a value-derived count of LEDs of the result colour.
// - Negative option off blanks the bar for negative results.
// - Negative option on uses the magnitude of a negative result.
// - A near-zero threshold of zero disables near-zero gating.
// - Comparison starts only once weight exceeds the near-zero threshold.
// - A near-zero threshold below twenty divisions counts as twenty.
package wlc_pkg;
    localparam int VW = 20;
    localparam int AW = 8;
    localparam int DIGITS = 6;
    localparam int BAR_STEPS = 24;
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_LOW = 8'h04;
    localparam logic [AW-1:0] OFS_HIGH = 8'h08;
    localparam logic [AW-1:0] OFS_NEARZ = 8'h0c;
    localparam logic [AW-1:0] OFS_SPAN = 8'h10;
    localparam logic [AW-1:0] OFS_STATUS = 8'h14;
    localparam logic [VW-1:0] MIN_DIV = 20'h00014;
    localparam logic [VW-1:0] LIMIT_RST = 20'h00000;
    localparam logic [VW-1:0] NEARZ_RST = 20'h00000;
    localparam logic [VW-1:0] SPAN_RST = 20'h003e8;
    localparam logic [2:0] NDIG_MAX = 3'h6;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] KEY_CONFIRM = 4'ha;
    localparam logic [3:0] KEY_CLEAR = 4'hb;
    localparam logic [3:0] KEY_CHECK = 4'hc;
    localparam logic [2:0] STYLE_OFF = 3'h0;
    localparam logic [2:0] STYLE_PROGRESS = 3'h1;
    localparam logic [2:0] STYLE_BAR = 3'h2;
    localparam logic [2:0] STYLE_DOT = 3'h3;
    localparam logic [2:0] STYLE_RANGE = 3'h4;

    typedef enum logic [1:0] {
        RES_NONE = 2'b00,
        RES_LO = 2'b01,
        RES_OK = 2'b10,
        RES_HI = 2'b11
    } wlc_res_t;

    typedef enum logic [1:0] {
        MODE_WEIGH = 2'b00,
        MODE_COUNT = 2'b01,
        MODE_ATM = 2'b10
    } wlc_mode_t;

    typedef enum logic [1:0] {
        ENT_IDLE = 2'b00,
        ENT_LOW = 2'b01,
        ENT_HIGH = 2'b10
    } wlc_ent_t;

    typedef struct packed {
        logic check_en;
        logic neg_on;
        logic [2:0] style;
        logic [1:0] mode;
    } wlc_ctrl_t;

    localparam wlc_ctrl_t CTRL_RST = 7'h00;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] yellow;
    } wlc_bar_t;
endpackage : wlc_pkg

/* File: wlc_seg_cmp.sv */
// One threshold step of the light bar position scale
`timescale 1ns/100ps
module wlc_seg_cmp #(
    parameter int K = 0
) (
    // Value and full-scale span
    input wire logic [wlc_pkg::VW-1:0] value,
    input wire logic [wlc_pkg::VW-1:0] span,
    // Step reached
    output logic hit
);
    localparam logic [25:0] STEPS = 26'(wlc_pkg::BAR_STEPS);
    localparam logic [25:0] KK = 26'(K);
    wire logic [25:0] val_scaled;
    wire logic [25:0] span_scaled;

    // Multiply instead of divide: compares value/span against K/24
    assign val_scaled = {6'h00, value} * STEPS;
    assign span_scaled = {6'h00, span} * KK;
    assign hit = (val_scaled >= span_scaled);
endmodule : wlc_seg_cmp

/* File: wlc_limit_check.sv */
// Limit check with keypad entry, register port and tri-colour light bar
`timescale 1ns/100ps
module wlc_limit_check (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [wlc_pkg::AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Operator keypad
    input wire logic key_strobe,
    input wire logic [3:0] key_code,
    // Measurement front end, same clock
    input wire logic signed [wlc_pkg::VW:0] meas_weight,
    input wire logic signed [wlc_pkg::VW:0] meas_count,
    // Light bar and result
    output wlc_pkg::wlc_bar_t bar,
    output wlc_pkg::wlc_res_t check_result
);
    localparam int VW = wlc_pkg::VW;

    // Register state
    wlc_pkg::wlc_ctrl_t ctrl_reg, ctrl_next;
    logic [VW-1:0] low_reg, low_next;
    logic [VW-1:0] high_reg, high_next;
    logic [VW-1:0] nearz_reg, nearz_next;
    logic [VW-1:0] span_reg, span_next;
    logic [31:0] rdata_reg, rdata_next;

    // Keypad entry state
    wlc_pkg::wlc_ent_t ent_reg, ent_next;
    logic [VW-1:0] acc_reg, acc_next;
    logic [2:0] ndig_reg, ndig_next;
    logic typed_reg, typed_next;
    logic clr_reg, clr_next;

    // Keypad synchronisers
    logic stb_s1, stb_s2, stb_s3;
    logic [3:0] code_s1, code_s2;

    // Outputs and style seen with them
    wlc_pkg::wlc_bar_t bar_reg, bar_next;
    wlc_pkg::wlc_res_t res_reg, res_next;
    logic [2:0] style_q;

    // Address decode
    wire logic hit_ctrl = (reg_addr == wlc_pkg::OFS_CTRL);
    wire logic hit_low = (reg_addr == wlc_pkg::OFS_LOW);
    wire logic hit_high = (reg_addr == wlc_pkg::OFS_HIGH);
    wire logic hit_nearz = (reg_addr == wlc_pkg::OFS_NEARZ);
    wire logic hit_span = (reg_addr == wlc_pkg::OFS_SPAN);
    wire logic hit_status = (reg_addr == wlc_pkg::OFS_STATUS);
    wire logic wr_ctrl = reg_wr && hit_ctrl;
    wire logic wr_low = reg_wr && hit_low;
    wire logic wr_high = reg_wr && hit_high;
    wire logic wr_nearz = reg_wr && hit_nearz;
    wire logic wr_span = reg_wr && hit_span;

    // Keypad events, taken from the synchronised strobe edge
    wire logic key_evt = stb_s2 && !stb_s3;
    wire logic key_digit = key_evt && (code_s2 <= wlc_pkg::DIGIT_MAX);
    wire logic key_confirm = key_evt && (code_s2 == wlc_pkg::KEY_CONFIRM);
    wire logic key_clear = key_evt && (code_s2 == wlc_pkg::KEY_CLEAR);
    wire logic key_check = key_evt && (code_s2 == wlc_pkg::KEY_CHECK);
    wire logic commit_high = key_confirm && (ent_reg == wlc_pkg::ENT_HIGH);

    // Result selection and sign handling
    wire logic counting = (ctrl_reg.mode == wlc_pkg::MODE_COUNT);
    wire logic signed [VW:0] sel_val = counting ? meas_count : meas_weight;
    wire logic sel_neg = sel_val[VW];
    wire logic [VW:0] sel_abs = sel_neg ? (-sel_val) : sel_val;
    wire logic [VW-1:0] res_mag = sel_abs[VW-1:0];
    wire logic w_neg = meas_weight[VW];
    wire logic [VW:0] w_abs = w_neg ? (-meas_weight) : meas_weight;
    wire logic [VW-1:0] wmag = w_abs[VW-1:0];

    // Gating
    wire logic neg_blank = sel_neg && !ctrl_reg.neg_on;
    wire logic min_ok = (wmag >= wlc_pkg::MIN_DIV);
    wire logic [VW-1:0] nz_eff = (nearz_reg < wlc_pkg::MIN_DIV) ?
        wlc_pkg::MIN_DIV : nearz_reg;
    wire logic nz_ok = (nearz_reg == '0) || (wmag > nz_eff);
    wire logic active = ctrl_reg.check_en && !neg_blank && min_ok && nz_ok;

    // Limit compares
    wire logic low_zero = (low_reg == '0);
    wire logic high_zero = (high_reg == '0);
    wire logic at_or_below = (res_mag <= low_reg);
    wire logic at_or_above = (res_mag >= high_reg);
    wire logic equal_lim = (low_reg == high_reg);

    // Bar position thermometer over 24 steps
    logic [wlc_pkg::BAR_STEPS-1:0] therm24;
    logic [7:0] therm8;
    logic [7:0] dot8;

    genvar gk;
    generate
        for (gk = 0; gk < wlc_pkg::BAR_STEPS; gk++) begin : g_step
            wlc_seg_cmp #(
                .K(gk)
            ) u_step (
                .value(res_mag),
                .span(span_reg),
                .hit(therm24[gk])
            );
        end
        for (gk = 0; gk < 8; gk++) begin : g_eight
            assign therm8[gk] = therm24[3*gk];
        end
    endgenerate

    // Highest lit step only
    assign dot8 = therm8 & ~(therm8 >> 1);

    // Status word
    wire logic [31:0] status_word = {26'h0, ent_reg, ctrl_reg.check_en,
        active, res_reg};

    // Read mux; unmapped addresses read zero
    wire logic [31:0] rd_mux =
        hit_ctrl ? {25'h0, ctrl_reg} :
        hit_low ? {12'h0, low_reg} :
        hit_high ? {12'h0, high_reg} :
        hit_nearz ? {12'h0, nearz_reg} :
        hit_span ? {12'h0, span_reg} :
        hit_status ? status_word : 32'h0;

    assign reg_rdata = rdata_reg;
    assign bar = bar_reg;
    assign check_result = res_reg;

    // Place an 8-LED pattern in the colour of the result
    function automatic wlc_pkg::wlc_bar_t paint(
        input wlc_pkg::wlc_res_t r,
        input logic [7:0] pat
    );
        wlc_pkg::wlc_bar_t b;
        b = '0;
        case (r)
            wlc_pkg::RES_LO: b.yellow = pat;
            wlc_pkg::RES_OK: b.green = pat;
            wlc_pkg::RES_HI: b.red = pat;
            default: b = '0;
        endcase
        return b;
    endfunction : paint

    // Classification
    always_comb begin
        res_next = wlc_pkg::RES_NONE;
        if (active) begin
            if (high_zero) begin
                res_next = at_or_below ? wlc_pkg::RES_LO :
                    wlc_pkg::RES_OK;
            end else if (low_zero) begin
                res_next = at_or_above ? wlc_pkg::RES_HI :
                    wlc_pkg::RES_OK;
            end else if (equal_lim) begin
                res_next = (res_mag == low_reg) ? wlc_pkg::RES_OK :
                    (res_mag < low_reg) ? wlc_pkg::RES_LO :
                    wlc_pkg::RES_HI;
            end else if (at_or_below) begin
                res_next = wlc_pkg::RES_LO;
            end else if (at_or_above) begin
                res_next = wlc_pkg::RES_HI;
            end else begin
                res_next = wlc_pkg::RES_OK;
            end
        end
    end

    // Light bar pattern
    always_comb begin
        bar_next = '0;
        if (res_next != wlc_pkg::RES_NONE) begin
            case (ctrl_reg.style)
                wlc_pkg::STYLE_OFF: bar_next = '0;
                wlc_pkg::STYLE_PROGRESS: bar_next = therm24;
                wlc_pkg::STYLE_BAR: bar_next = paint(res_next, 8'hff);
                wlc_pkg::STYLE_DOT: bar_next = paint(res_next, dot8);
                wlc_pkg::STYLE_RANGE: bar_next = paint(res_next, therm8);
                default: bar_next = '0;
            endcase
        end
    end

    // Register writes and keypad limit entry
    always_comb begin
        ctrl_next = ctrl_reg;
        low_next = low_reg;
        high_next = high_reg;
        nearz_next = nearz_reg;
        span_next = span_reg;
        ent_next = ent_reg;
        acc_next = acc_reg;
        ndig_next = ndig_reg;
        typed_next = typed_reg;
        clr_next = clr_reg;
        if (wr_ctrl) begin
            ctrl_next = reg_wdata[6:0];
        end
        if (wr_low) begin
            low_next = reg_wdata[VW-1:0];
        end
        if (wr_high) begin
            high_next = reg_wdata[VW-1:0];
        end
        if (wr_nearz) begin
            nearz_next = reg_wdata[VW-1:0];
        end
        if (wr_span) begin
            span_next = reg_wdata[VW-1:0];
        end
        // Keypad wins over a bus write in the same cycle
        case (ent_reg)
            wlc_pkg::ENT_IDLE: begin
                if (key_check) begin
                    ent_next = wlc_pkg::ENT_LOW;
                    acc_next = '0;
                    ndig_next = '0;
                    typed_next = 1'b0;
                    clr_next = 1'b0;
                end
            end
            wlc_pkg::ENT_LOW, wlc_pkg::ENT_HIGH: begin
                if (key_digit && ndig_reg < wlc_pkg::NDIG_MAX) begin
                    acc_next = acc_reg * 20'd10 + {16'h0, code_s2};
                    ndig_next = ndig_reg + 3'h1;
                    typed_next = 1'b1;
                end else if (key_clear) begin
                    acc_next = '0;
                    ndig_next = '0;
                    typed_next = 1'b1;
                    clr_next = 1'b1;
                end else if (key_confirm) begin
                    acc_next = '0;
                    ndig_next = '0;
                    typed_next = 1'b0;
                    if (ent_reg == wlc_pkg::ENT_LOW) begin
                        if (typed_reg) begin
                            low_next = acc_reg;
                        end
                        ent_next = wlc_pkg::ENT_HIGH;
                    end else begin
                        if (typed_reg) begin
                            high_next = acc_reg;
                        end
                        ent_next = wlc_pkg::ENT_IDLE;
                        ctrl_next.check_en = !clr_reg;
                    end
                end
            end
            default: ent_next = wlc_pkg::ENT_IDLE;
        endcase
    end

    // Keypad pins cross in through two flip-flops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stb_s1 <= 1'b0;
            stb_s2 <= 1'b0;
            stb_s3 <= 1'b0;
            code_s1 <= 4'h0;
            code_s2 <= 4'h0;
        end else begin
            stb_s1 <= key_strobe;
            stb_s2 <= stb_s1;
            stb_s3 <= stb_s2;
            code_s1 <= key_code;
            code_s2 <= code_s1;
        end
    end

    // Configuration and entry state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= wlc_pkg::CTRL_RST;
            low_reg <= wlc_pkg::LIMIT_RST;
            high_reg <= wlc_pkg::LIMIT_RST;
            nearz_reg <= wlc_pkg::NEARZ_RST;
            span_reg <= wlc_pkg::SPAN_RST;
            ent_reg <= wlc_pkg::ENT_IDLE;
            acc_reg <= '0;
            ndig_reg <= '0;
            typed_reg <= 1'b0;
            clr_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            low_reg <= low_next;
            high_reg <= high_next;
            nearz_reg <= nearz_next;
            span_reg <= span_next;
            ent_reg <= ent_next;
            acc_reg <= acc_next;
            ndig_reg <= ndig_next;
            typed_reg <= typed_next;
            clr_reg <= clr_next;
        end
    end

    // Outputs; read data is only meaningful the cycle after a read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0;
            bar_reg <= '0;
            res_reg <= wlc_pkg::RES_NONE;
            style_q <= wlc_pkg::STYLE_OFF;
        end else begin
            rdata_reg <= reg_rd ? rd_mux : 32'h0;
            bar_reg <= bar_next;
            res_reg <= res_next;
            style_q <= ctrl_reg.style;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_style_dark: assert property (
        style_q == wlc_pkg::STYLE_OFF |-> bar_reg == '0)
        else $error("bar lit in style 0");

    a_single_bar: assert property (
        (style_q == wlc_pkg::STYLE_BAR && res_reg == wlc_pkg::RES_LO)
        |-> (bar_reg.yellow == 8'hff && bar_reg.green == 8'h00
        && bar_reg.red == 8'h00))
        else $error("single bar style wrong for LO");

    a_dot_one: assert property (
        (style_q == wlc_pkg::STYLE_DOT && res_reg != wlc_pkg::RES_NONE)
        |-> $onehot(bar_reg))
        else $error("dot style not one LED");

    a_below_min: assert property (
        (wmag < wlc_pkg::MIN_DIV) |=> res_reg == wlc_pkg::RES_NONE)
        else $error("checked below twenty divisions");

    a_neg_blank: assert property (
        (sel_neg && !ctrl_reg.neg_on) |=> bar_reg == '0)
        else $error("bar lit for negative result");

    a_high_zero: assert property (
        (active && high_zero) |=> res_reg != wlc_pkg::RES_HI)
        else $error("HI reported with zero high limit");

    a_low_zero: assert property (
        (active && low_zero && !high_zero) |=> res_reg != wlc_pkg::RES_LO)
        else $error("LO reported with zero low limit");

    a_equal_ok: assert property (
        (active && equal_lim && !low_zero && res_mag == low_reg)
        |=> res_reg == wlc_pkg::RES_OK)
        else $error("equality check failed");

    a_nearz_gate: assert property (
        (nearz_reg != '0 && wmag <= nz_eff) |=> res_reg == wlc_pkg::RES_NONE)
        else $error("checked at or below near-zero value");

    a_entry_done: assert property (
        (commit_high && !clr_reg) |=> (ctrl_reg.check_en
        && ent_reg == wlc_pkg::ENT_IDLE))
        else $error("check not enabled after entry");

    c_lo_seen: cover property (res_reg == wlc_pkg::RES_LO);
    c_ok_seen: cover property (res_reg == wlc_pkg::RES_OK);
    c_hi_seen: cover property (res_reg == wlc_pkg::RES_HI);
    c_entry_path: cover property (key_check ##[1:200] commit_high);
endmodule : wlc_limit_check

/* File: wlc_keypad_model.sv */
// Operator keypad model for the limit-check block
`timescale 1ns/100ps
module wlc_keypad_model (
    // Clock
    input wire logic clk,
    // Keypad lines
    output logic key_strobe,
    output logic [3:0] key_code
);
    initial begin
        key_strobe = 1'b0;
        key_code = 4'h0;
    end

    // Code held from before the strobe rises until after it falls
    task automatic press(input logic [3:0] k);
        @(posedge clk);
        key_code <= k;
        @(posedge clk);
        key_strobe <= 1'b1;
        repeat (2) @(posedge clk);
        key_strobe <= 1'b0;
        // No pull on the code lines, so a stale code must not look valid
        @(posedge clk);
        key_code <= ~k;
        repeat (4) @(posedge clk);
    endtask : press

    // Six decimal digits, most significant first
    task automatic digits(input logic [23:0] v);
        for (int i = 5; i >= 0; i--) begin
            press(v[i*4 +: 4]);
        end
    endtask : digits

    // Check key, low limit, confirm, high limit, confirm
    task automatic enter(input logic [23:0] lo, input logic [23:0] hi);
        press(wlc_pkg::KEY_CHECK);
        digits(lo);
        press(wlc_pkg::KEY_CONFIRM);
        digits(hi);
        press(wlc_pkg::KEY_CONFIRM);
    endtask : enter
endmodule : wlc_keypad_model

/* File: wlc_limit_check_bench.sv */
// Self-checking bench for the limit-check block
`timescale 1ns/100ps
module wlc_limit_check_bench;
    logic clk;
    logic sys_rst;
    logic [wlc_pkg::AW-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic key_strobe;
    logic [3:0] key_code;
    logic signed [wlc_pkg::VW:0] meas_weight;
    logic signed [wlc_pkg::VW:0] meas_count;
    wlc_pkg::wlc_bar_t bar;
    wlc_pkg::wlc_res_t check_result;
    int err_total;
    int check_count;
    logic [7:0] pats [0:4];

    wlc_limit_check wlc_limit_check_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .key_strobe(key_strobe),
        .key_code(key_code),
        .meas_weight(meas_weight),
        .meas_count(meas_count),
        .bar(bar),
        .check_result(check_result)
    );

    wlc_keypad_model wlc_keypad_model_inst (
        .clk(clk),
        .key_strobe(key_strobe),
        .key_code(key_code)
    );

    initial clk = 1'b0;
    always #10 clk = ~clk;

    task automatic summarize;
        $display("Checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk_word

    task automatic chk_res(input wlc_pkg::wlc_res_t e);
        check_count++;
        if (check_result !== e) begin
            err_total++;
            $display("Error result expected %h seen %h", e, check_result);
        end
    endtask : chk_res

    task automatic chk_bar(input wlc_pkg::wlc_bar_t e);
        check_count++;
        if (bar !== e) begin
            err_total++;
            $display("Error bar expected %h seen %h", e, bar);
        end
    endtask : chk_bar

    // Register port: single-cycle strobes, read data in the next cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk_word($sformatf("reg %h", a), e, reg_rdata);
    endtask : rchk

    // Enable bit always set; style, negative option and mode vary
    task automatic ctl(input logic [2:0] s, input logic n,
                       input logic [1:0] m);
        wr(wlc_pkg::OFS_CTRL, {25'h0000000, 1'b1, n, s, m});
    endtask : ctl

    // Apply a reading, let the registered outputs settle, compare both
    task automatic look(input int w, input int c, input wlc_pkg::wlc_res_t r,
                        input logic [7:0] p);
        wlc_pkg::wlc_bar_t b;
        b = '0;
        b.yellow = (r == wlc_pkg::RES_LO) ? p : 8'h00;
        b.green = (r == wlc_pkg::RES_OK) ? p : 8'h00;
        b.red = (r == wlc_pkg::RES_HI) ? p : 8'h00;
        @(posedge clk);
        meas_weight <= w[wlc_pkg::VW:0];
        meas_count <= c[wlc_pkg::VW:0];
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_res(r);
        chk_bar(b);
    endtask : look

    initial begin
        repeat (100000) @(posedge clk);
        $display("Error watchdog expected finish seen hang");
        err_total++;
        summarize();
    end

    initial begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        meas_weight = '0;
        meas_count = '0;
        err_total = 0;
        check_count = 0;
        pats = '{8'h00, 8'h00, 8'hff, 8'h02, 8'h03};
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rchk(wlc_pkg::OFS_CTRL, 32'h00000000);
        rchk(wlc_pkg::OFS_SPAN, 32'h000003e8);
        rchk(wlc_pkg::OFS_STATUS, 32'h00000000);
        wr(8'h18, 32'hffffffff);
        rchk(8'h18, 32'h00000000);
        chk_res(wlc_pkg::RES_NONE);
        // Keypad entry of 40 and 60 enables checking
        wlc_keypad_model_inst.enter(24'h000040, 24'h000060);
        rchk(wlc_pkg::OFS_LOW, 32'h00000028);
        rchk(wlc_pkg::OFS_HIGH, 32'h0000003c);
        rchk(wlc_pkg::OFS_STATUS, 32'h00000008);
        ctl(wlc_pkg::STYLE_BAR, 1'b0, wlc_pkg::MODE_WEIGH);
        look(30, 30, wlc_pkg::RES_LO, 8'hff);
        look(40, 40, wlc_pkg::RES_LO, 8'hff);
        look(50, 50, wlc_pkg::RES_OK, 8'hff);
        rchk(wlc_pkg::OFS_STATUS, 32'h0000000e);
        look(60, 60, wlc_pkg::RES_HI, 8'hff);
        look(19, 19, wlc_pkg::RES_NONE, 8'h00);
        look(20, 20, wlc_pkg::RES_LO, 8'hff);
        // Counting compares the count, weighing and auto tare the weight
        ctl(wlc_pkg::STYLE_BAR, 1'b0, wlc_pkg::MODE_COUNT);
        look(50, 70, wlc_pkg::RES_HI, 8'hff);
        look(19, 50, wlc_pkg::RES_NONE, 8'h00);
        ctl(wlc_pkg::STYLE_BAR, 1'b0, wlc_pkg::MODE_ATM);
        look(50, 70, wlc_pkg::RES_OK, 8'hff);
        ctl(wlc_pkg::STYLE_BAR, 1'b0, wlc_pkg::MODE_WEIGH);
        look(-50, -50, wlc_pkg::RES_NONE, 8'h00);
        ctl(wlc_pkg::STYLE_BAR, 1'b1, wlc_pkg::MODE_WEIGH);
        look(-50, -50, wlc_pkg::RES_OK, 8'hff);
        // Near-zero gate: strictly above, floor of twenty, zero disables
        wr(wlc_pkg::OFS_NEARZ, 32'h0000002d);
        rchk(wlc_pkg::OFS_NEARZ, 32'h0000002d);
        look(45, 45, wlc_pkg::RES_NONE, 8'h00);
        look(46, 46, wlc_pkg::RES_OK, 8'hff);
        wr(wlc_pkg::OFS_NEARZ, 32'h00000005);
        look(20, 20, wlc_pkg::RES_NONE, 8'h00);
        look(21, 21, wlc_pkg::RES_LO, 8'hff);
        wr(wlc_pkg::OFS_NEARZ, 32'h00000000);
        look(20, 20, wlc_pkg::RES_LO, 8'hff);
        // One-sided and equality checks
        wr(wlc_pkg::OFS_HIGH, 32'h00000000);
        look(40, 40, wlc_pkg::RES_LO, 8'hff);
        look(41, 41, wlc_pkg::RES_OK, 8'hff);
        wr(wlc_pkg::OFS_LOW, 32'h00000000);
        wr(wlc_pkg::OFS_HIGH, 32'h0000003c);
        look(59, 59, wlc_pkg::RES_OK, 8'hff);
        look(60, 60, wlc_pkg::RES_HI, 8'hff);
        wr(wlc_pkg::OFS_LOW, 32'h00000032);
        wr(wlc_pkg::OFS_HIGH, 32'h00000032);
        look(49, 49, wlc_pkg::RES_LO, 8'hff);
        look(50, 50, wlc_pkg::RES_OK, 8'hff);
        look(51, 51, wlc_pkg::RES_HI, 8'hff);
        // Styles; span 240 puts 52 at step 5, clear of any boundary
        wr(wlc_pkg::OFS_LOW, 32'h00000028);
        wr(wlc_pkg::OFS_HIGH, 32'h0000003c);
        wr(wlc_pkg::OFS_SPAN, 32'h000000f0);
        for (int s = 0; s < 5; s++) begin
            ctl(s[2:0], 1'b0, wlc_pkg::MODE_WEIGH);
            if (s != 1) begin
                look(52, 52, wlc_pkg::RES_OK, pats[s]);
            end else begin
                look(32, 32, wlc_pkg::RES_LO, 8'h0f);
            end
        end
        ctl(wlc_pkg::STYLE_DOT, 1'b0, wlc_pkg::MODE_WEIGH);
        look(100, 100, wlc_pkg::RES_HI, 8'h08);
        // Seventh digit ignored; confirm with no digit keeps the high limit
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CHECK);
        wlc_keypad_model_inst.digits(24'h000045);
        wlc_keypad_model_inst.press(4'h7);
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CONFIRM);
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CONFIRM);
        rchk(wlc_pkg::OFS_LOW, 32'h0000002d);
        rchk(wlc_pkg::OFS_HIGH, 32'h0000003c);
        // Clearing both limits cancels checking
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CHECK);
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CLEAR);
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CONFIRM);
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CLEAR);
        wlc_keypad_model_inst.press(wlc_pkg::KEY_CONFIRM);
        rchk(wlc_pkg::OFS_LOW, 32'h00000000);
        rchk(wlc_pkg::OFS_HIGH, 32'h00000000);
        rchk(wlc_pkg::OFS_STATUS, 32'h00000000);
        look(50, 50, wlc_pkg::RES_NONE, 8'h00);
        summarize();
    end
endmodule : wlc_limit_check_bench
